// ### hw/peripheral_expander_channel.sv
// peripheral expander channel: function decode, flags, expander bus sequencing
`timescale 1ns/1ps
module peripheral_expander_channel
   import expander_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // function requests from the io processor
   input wire logic expander_function,
   input wire logic [3:0] func_code,
   input wire logic [15:0] accumulator,
   output logic [15:0] read_data,
   output logic channel_irq,
   output logic dma_enable,
   // expander data bus
   input wire logic bus_free,
   input wire logic [15:0] bus_data_in,
   input wire logic [5:0] bus_irq_code,
   input wire logic controller_irq_request,
   input wire logic selected_device_busy,
   input wire logic selected_device_done,
   output logic bus_strobe,
   output logic [2:0] bus_op,
   output logic [1:0] bus_reg_sel,
   output logic [5:0] bus_address,
   output logic [15:0] bus_data_out,
   // control lines
   output logic ctl_start,
   output logic ctl_clear,
   output logic ctl_pulse,
   output logic controller_bus_reset
);
   typedef enum logic [1:0] {IDLE, ISSUED, WAIT_BUS, ON_BUS} phase_e;
   typedef struct packed {
      phase_e phase;
      logic [7:0] count;
      logic [2:0] op;
      logic [1:0] reg_sel;
      logic [15:0] out_word;
      logic [15:0] bus_word;
      logic [5:0] irq_code;
      logic [5:0] dev_addr;
      logic chan_ie;
      logic ctrl_ie;
      logic dma_en;
      logic busy;
      logic done;
      logic [15:0] rdata;
   } state_s;
   state_s st;
   state_s next_st;
   logic [15:0] status_common;
   logic is_delayed;
   always_comb begin
      status_common = RESET_WORD;
      status_common[ST_DMA] = st.dma_en;
      status_common[ST_CHAN_IE] = st.chan_ie;
      status_common[ST_CTRL_IE] = st.ctrl_ie;
      status_common[ST_ACTIVE] = (st.phase != IDLE);
      status_common[ST_BUSY] = st.busy;
      status_common[ST_DONE] = st.done;
      status_common[ST_CONTROLLER_IRQ_REQUEST] = controller_irq_request;
      status_common[ST_SELECTED_DEVICE_BUSY] = selected_device_busy;
      status_common[ST_SELECTED_DEVICE_DONE] = selected_device_done;
   end
   always_comb begin
      case (func_code)
         FN_DIN_A, FN_DIN_B, FN_DIN_C, FN_BUSY_DONE, FN_MASK_OUT,
         FN_DOUT_A, FN_DOUT_B, FN_DOUT_C, FN_CONTROL: is_delayed = 1'b1;
         default: is_delayed = 1'b0;
      endcase
   end
   always_comb begin
      next_st = st;
      case (st.phase)
         ISSUED: begin
            // flags move one clock after issue
            next_st.busy = 1'b1;
            next_st.done = 1'b0;
            next_st.phase = WAIT_BUS;
         end
         WAIT_BUS: begin
            if (bus_free) begin
               next_st.phase = ON_BUS;
               next_st.count = BUS_DELAY_LAST;
            end
         end
         ON_BUS: begin
            // a fixed 1 us bus cycle paces one parcel per microsecond
            if (st.count == 8'h00) begin
               next_st.phase = IDLE;
               next_st.busy = 1'b0;
               next_st.done = 1'b1;
               if (st.op == OP_READ) begin
                  next_st.bus_word = bus_data_in;
               end
               if (st.op == OP_POLL) begin
                  next_st.irq_code = bus_irq_code;
               end
            end else begin
               next_st.count = st.count - 8'h01;
            end
         end
         default: next_st.phase = IDLE;
      endcase
      if (expander_function) begin
         // a delayed request overlapping the previous one is the processor's fault
         if (is_delayed && st.phase == IDLE) begin
            next_st.phase = ISSUED;
            next_st.out_word = accumulator;
            next_st.reg_sel = 2'(func_code[1:0]);
         end
         case (func_code)
            FN_IDLE: begin
               // a flag set by the sequence in this same cycle wins over the clear
               if (st.phase != ISSUED) begin
                  next_st.busy = 1'b0;
               end
               if (!(st.phase == ON_BUS && st.count == 8'h00)) begin
                  next_st.done = 1'b0;
               end
               next_st.chan_ie = 1'b0;
               next_st.dma_en = 1'b0;
            end
            FN_DIN_A, FN_DIN_B, FN_DIN_C: next_st.op = OP_READ;
            FN_BUSY_DONE: next_st.op = OP_POLL;
            FN_LOAD_ADDR: next_st.dev_addr = accumulator[5:0];
            FN_MASK_OUT: next_st.op = OP_MASK;
            FN_INT_MODE: begin
               next_st.chan_ie = accumulator[0];
               next_st.ctrl_ie = accumulator[1];
            end
            FN_READ_BUS: next_st.rdata = st.bus_word;
            FN_STATUS1: next_st.rdata = {status_common[15:6], st.irq_code};
            FN_STATUS2: next_st.rdata = {status_common[15:6], st.dev_addr};
            FN_DOUT_A, FN_DOUT_B, FN_DOUT_C: begin
               next_st.op = OP_WRITE;
               next_st.reg_sel = 2'(func_code - FN_DOUT_A);
            end
            FN_CONTROL: next_st.op = OP_CONTROL;
            default: ;
         endcase
         if (!(is_delayed && st.phase == IDLE)) begin
            next_st.op = st.op;
            next_st.reg_sel = st.reg_sel;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{phase: IDLE, count: 8'h00, op: OP_READ, reg_sel: 2'h0,
                 out_word: RESET_WORD, bus_word: RESET_WORD, irq_code: RESET_ADDR,
                 dev_addr: RESET_ADDR, chan_ie: 1'b0, ctrl_ie: 1'b0, dma_en: 1'b0,
                 busy: 1'b0, done: 1'b0, rdata: RESET_WORD};
      end else begin
         st <= next_st;
      end
   end
   logic on_bus;
   assign on_bus = (st.phase == ON_BUS);
   assign read_data = st.rdata;
   assign dma_enable = st.dma_en;
   assign channel_irq = (st.done & st.chan_ie) | (controller_irq_request & st.ctrl_ie);
   assign bus_strobe = on_bus;
   assign bus_op = st.op;
   assign bus_reg_sel = st.reg_sel;
   assign bus_address = st.dev_addr;
   assign bus_data_out = st.out_word;
   assign ctl_start = on_bus && st.op == OP_CONTROL && st.out_word[0];
   assign ctl_clear = on_bus && st.op == OP_CONTROL && st.out_word[1];
   assign ctl_pulse = on_bus && st.op == OP_CONTROL && st.out_word[2];
   assign controller_bus_reset = on_bus && st.op == OP_CONTROL && st.out_word[3];
   // assertions
   sequence s_issue_delayed;
      expander_function && is_delayed && st.phase == IDLE;
   endsequence
   sequence s_busy_raised;
      st.busy && !st.done;
   endsequence
   a_issue_sets_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_issue_delayed |=> ##1 s_busy_raised) else $error("busy not set after issue");
   a_done_clears_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(st.done) |-> !st.busy) else $error("done and busy together");
   a_bus_waits_free: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st.phase == WAIT_BUS && !bus_free) |=> st.phase == WAIT_BUS)
      else $error("bus used while not free");
   a_input_delay: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(on_bus) |-> on_bus [*8] ##0 !st.done) else $error("bus cycle too short");
   a_int_mode_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
      (expander_function && func_code == FN_INT_MODE) |=>
      st.chan_ie == $past(accumulator[0]) && st.ctrl_ie == $past(accumulator[1]))
      else $error("interrupt mode mismatch");
   a_idle_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      (expander_function && func_code == FN_IDLE && st.phase == IDLE) |=>
      !st.busy && !st.done && !st.chan_ie && !st.dma_en) else $error("idle left flags");
   a_status2_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
      (expander_function && func_code == FN_STATUS2) |=> read_data[5:0] == st.dev_addr)
      else $error("status 2 address wrong");
   a_irq_from_done: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st.done && st.chan_ie) |-> channel_irq) else $error("missing channel interrupt");
   a_active_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_issue_delayed |=> status_common[ST_ACTIVE]) else $error("active bit not set");
   a_reset_line: assert property (@(posedge sys_clk) disable iff (!nrst)
      controller_bus_reset |-> on_bus && st.out_word[3]) else $error("stray reset line");
   a_write_word: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_issue_delayed |=> bus_data_out == $past(accumulator))
      else $error("output word not captured at issue");
   a_overlap_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
      (expander_function && is_delayed && st.phase != IDLE) |=>
      st.op == $past(st.op) && bus_data_out == $past(bus_data_out))
      else $error("overlapping request disturbed the transfer");
endmodule : peripheral_expander_channel

// ### hw/expander_pkg.sv
// constants for the peripheral expander channel
package expander_pkg;
   // function codes (octal as printed)
   localparam logic [3:0] FN_IDLE = 4'h0;
   localparam logic [3:0] FN_DIN_A = 4'h1;
   localparam logic [3:0] FN_DIN_B = 4'h2;
   localparam logic [3:0] FN_DIN_C = 4'h3;
   localparam logic [3:0] FN_BUSY_DONE = 4'h4;
   localparam logic [3:0] FN_LOAD_ADDR = 4'h5;
   localparam logic [3:0] FN_MASK_OUT = 4'h6;
   localparam logic [3:0] FN_INT_MODE = 4'h7;
   localparam logic [3:0] FN_READ_BUS = 4'h8;
   localparam logic [3:0] FN_STATUS1 = 4'h9;
   localparam logic [3:0] FN_STATUS2 = 4'hB;
   localparam logic [3:0] FN_DOUT_A = 4'hC;
   localparam logic [3:0] FN_DOUT_B = 4'hD;
   localparam logic [3:0] FN_DOUT_C = 4'hE;
   localparam logic [3:0] FN_CONTROL = 4'hF;
   // expander bus operation kinds
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_POLL = 3'h2;
   localparam logic [2:0] OP_MASK = 3'h3;
   localparam logic [2:0] OP_CONTROL = 3'h4;
   // status word fields
   localparam int ST_DMA = 7;
   localparam int ST_CHAN_IE = 8;
   localparam int ST_CTRL_IE = 9;
   localparam int ST_ACTIVE = 10;
   localparam int ST_BUSY = 11;
   localparam int ST_DONE = 12;
   localparam int ST_CONTROLLER_IRQ_REQUEST = 13;
   localparam int ST_SELECTED_DEVICE_BUSY = 14;
   localparam int ST_SELECTED_DEVICE_DONE = 15;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int BUS_DELAY_NS = 1000;
   localparam int BUS_DELAY_CYC = (BUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] BUS_DELAY_LAST = 8'(BUS_DELAY_CYC - 1);
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [5:0] RESET_ADDR = 6'h00;
endpackage : expander_pkg

// ### verification/expander_chassis_model.sv
// behavioural expander chassis: controller registers, bus arbitration
`timescale 1ns/1ps
module expander_chassis_model
   import expander_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // expander bus from the channel
   input wire logic bus_strobe,
   input wire logic [2:0] bus_op,
   input wire logic [1:0] bus_reg_sel,
   input wire logic [5:0] bus_address,
   input wire logic [15:0] bus_data_out,
   input wire logic ctl_start,
   input wire logic ctl_clear,
   input wire logic ctl_pulse,
   input wire logic controller_bus_reset,
   // answers to the channel, and ctl_seen for the bench
   output logic bus_free,
   output logic [15:0] bus_data_in,
   output logic [5:0] bus_irq_code,
   output logic [3:0] ctl_seen
);
   logic [15:0] regs [64][3];
   int seed = 90953;
   initial begin
      bus_free = 1'b1;
      bus_data_in = 16'h0000;
      ctl_seen = 4'h0;
      bus_irq_code = 6'($random(seed));
      foreach (regs[a, r]) regs[a][r] = 16'h0000;
   end
   always @(posedge sys_clk) begin
      // other traffic holds the bus at times, never mid-transfer
      bus_free <= bus_strobe || (($random(seed) & 3) != 0);
      // undriven data toggles so stale values never look valid
      bus_data_in <= ~bus_data_in;
      if (bus_strobe && bus_op == OP_READ) begin
         bus_data_in <= regs[bus_address][bus_reg_sel - 2'h1];
      end
      if (bus_strobe && bus_op == OP_WRITE) begin
         regs[bus_address][bus_reg_sel] <= bus_data_out;
      end
      if (bus_strobe && bus_op == OP_CONTROL) begin
         ctl_seen <= {controller_bus_reset, ctl_pulse, ctl_clear, ctl_start};
      end
      if (controller_bus_reset) begin
         foreach (regs[a, r]) regs[a][r] <= 16'h0000;
      end
   end
endmodule : expander_chassis_model

// ### verification/peripheral_expander_channel_tb_top.sv
// self-checking bench for the peripheral expander channel
`timescale 1ns/1ps
module peripheral_expander_channel_tb_top;
   import expander_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic expander_function = 1'b0;
   logic [3:0] func_code = 4'h0;
   logic [15:0] accumulator = 16'h0000;
   logic controller_irq_request = 1'b0;
   logic selected_device_busy = 1'b0;
   logic selected_device_done = 1'b0;
   logic [15:0] read_data, bus_data_in, bus_data_out, v, d;
   logic channel_irq, dma_enable, bus_free, bus_strobe, ctl_start, ctl_clear, ctl_pulse;
   logic controller_bus_reset, chan_ie, ctrl_ie, done;
   logic [2:0] bus_op;
   logic [1:0] bus_reg_sel;
   logic [5:0] bus_address, bus_irq_code, addr;
   logic [3:0] ctl_seen;
   int seed = 90953;
   int n_mismatch = 0;
   int checks = 0;
   peripheral_expander_channel dut_u (.sys_clk, .nrst, .expander_function, .func_code,
      .accumulator, .read_data, .channel_irq, .dma_enable, .bus_free, .bus_data_in,
      .bus_irq_code, .controller_irq_request, .selected_device_busy, .selected_device_done,
      .bus_strobe, .bus_op, .bus_reg_sel, .bus_address, .bus_data_out, .ctl_start,
      .ctl_clear, .ctl_pulse, .controller_bus_reset);
   expander_chassis_model model_u (.sys_clk, .bus_strobe, .bus_op, .bus_reg_sel,
      .bus_address, .bus_data_out, .ctl_start, .ctl_clear, .ctl_pulse,
      .controller_bus_reset, .bus_free, .bus_data_in, .bus_irq_code, .ctl_seen);
   // expected status bits 15..7 from the bench's own flag copies
   function automatic logic [15:0] hi(input logic act);
      return 16'({selected_device_done, selected_device_busy, controller_irq_request,
         done & ~act, act, act, ctrl_ie, chan_ie, 1'b0});
   endfunction : hi
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one low cycle after each pulse, so back-to-back calls never re-drive in one step
   task automatic iss(input logic [3:0] c, input logic [15:0] a);
      func_code = c;
      accumulator = a;
      expander_function = 1'b1;
      @(negedge sys_clk);
      expander_function = 1'b0;
      @(negedge sys_clk);
   endtask : iss
   task automatic rd(input logic [3:0] c);
      iss(c, 16'h0000);
      v = read_data;
   endtask : rd
   // polling by status reads, so the wait also counts cycles
   task automatic dly(input logic [3:0] c, input logic [15:0] a);
      int n;
      n = 0;
      iss(c, a);
      @(negedge sys_clk);
      done = 1'b0;
      rd(FN_STATUS1);
      chk(16'(v[15:7]), hi(1'b1));
      while (v[ST_DONE] !== 1'b1 && n < 900) begin
         rd(FN_STATUS1);
         n += 2;
      end
      done = 1'b1;
      chk(16'(v[15:7]), hi(1'b0));
      chk(16'(n >= BUS_DELAY_CYC - 8), 16'h0001);
      chk(16'(channel_irq), 16'(chan_ie | controller_irq_request & ctrl_ie));
   endtask : dly
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      #(8 * 30000);
      n_mismatch++;
      summarize();
   end
   initial begin
      {chan_ie, ctrl_ie, done} = 3'h0;
      repeat (5) @(negedge sys_clk);
      nrst = 1'b1;
      @(negedge sys_clk);
      rd(FN_STATUS1);
      chk(v, RESET_WORD);
      for (int i = 0; i < 4; i++) begin
         {controller_irq_request, selected_device_busy, selected_device_done} = 3'($random(seed));
         iss(FN_INT_MODE, 16'(i));
         {ctrl_ie, chan_ie} = 2'(i);
         addr = 6'($random(seed));
         iss(FN_LOAD_ADDR, {10'h000, addr});
         rd(FN_STATUS2);
         chk(v, hi(1'b0) << 7 | 16'(addr));
         chk(16'(channel_irq), 16'(controller_irq_request & ctrl_ie));
      end
      $display("interrupt mode and address test ended");
      for (int i = 0; i < 3; i++) begin
         d = 16'($random(seed));
         dly(FN_DOUT_A + 4'(i), d);
         chk(model_u.regs[addr][i], d);
         dly(FN_DIN_A + 4'(i), 16'h0000);
         rd(FN_STATUS2);
         rd(FN_READ_BUS);
         chk(v, d);
      end
      dly(FN_MASK_OUT, 16'($random(seed)));
      dly(FN_BUSY_DONE, 16'h0000);
      rd(FN_STATUS1);
      chk(16'(v[5:0]), 16'(bus_irq_code));
      $display("data transfer test ended");
      for (int i = 1; i < 16; i++) begin
         dly(FN_CONTROL, 16'(i));
         chk(16'(ctl_seen), 16'(i));
      end
      chk(model_u.regs[addr][0], 16'h0000);
      $display("control test ended");
      iss(FN_IDLE, 16'h0000);
      @(negedge sys_clk);
      {done, chan_ie} = 2'h0;
      rd(FN_STATUS1);
      chk(16'(v[15:7]), hi(1'b0));
      chk(16'(dma_enable), 16'h0000);
      $display("idle test ended");
      summarize();
   end
endmodule : peripheral_expander_channel_tb_top
